// ---- logic/csg_pkg.sv ----
// Package with the register map, field layouts and types of the sense gating block
package csg_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] AMP_CFG_OFS = 8'h00;
    localparam logic [7:0] OCP_CFG_OFS = 8'h04;
    localparam logic [7:0] BLANK_CFG_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AMP_EN_POS = 0;
    localparam int SINGLE_SHUNT_POS = 3;
    localparam int RDSON_POS = 4;
    localparam int TMODE_POS = 5;
    localparam int OFS_SRC_POS = 7;
    localparam int REF_SCALE_POS = 8;
    localparam int PTHR_POS = 0;
    localparam int NTHR_POS = 4;
    localparam int DEGLITCH_POS = 8;
    localparam int TRUNC_DIS_POS = 10;
    localparam int LATCH_POS = 11;
    localparam int REPORT_DIS_POS = 12;
    localparam int BRAKE_EN_POS = 13;
    localparam int OCP_DIS_POS = 14;
    localparam int REPEAT_POS = 15;
    localparam int BLANK_POS = 0;
    localparam int ST_CONNECT_POS = 0;
    localparam int ST_BLANKING_POS = 3;
    localparam int ST_FAULT_POS = 4;
    localparam int ST_POS_CMP_POS = 5;
    localparam int ST_NEG_CMP_POS = 6;
    localparam int ST_TRUNC_POS = 7;
    localparam int ST_HAPPENED_POS = 8;

    // ------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [31:0] AMP_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] OCP_CFG_RST = 32'h0000_4000;
    localparam logic [31:0] BLANK_CFG_RST = 32'h0000_0000;
    localparam logic [4:0] REPEAT_COUNT = 5'h08;
    localparam logic [4:0] DEGLITCH_BASE = 5'h02;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSG_LOW_SIDE_ON_MODE,
        CSG_HIGH_SIDE_OFF_MODE,
        CSG_ALWAYS_ON_MODE,
        CSG_SPARE_MODE
    } csg_tmode_e;

    typedef struct packed {
        logic [2:0] ref_scale;
        logic offset_source_select;
        logic [1:0] timing_mode_field;
        logic rdson;
        logic single_shunt;
        logic [2:0] amp_en;
    } csg_amp_cfg_s;

    typedef struct packed {
        logic repeat_trip;
        logic ocp_dis;
        logic brake_en;
        logic report_dis;
        logic overcurrent_latch_field;
        logic truncation_disable_field;
        logic [1:0] overcurrent_deglitch_field;
        logic [3:0] negative_threshold_field;
        logic [3:0] positive_threshold_field;
    } csg_ocp_cfg_s;
endpackage

// ---- logic/csg_top.sv ----
// Current sense gating, blanking, offset select and over-current reaction
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps

// How it works
// RULE_01 - Channel with amplifier enable cleared stays disconnected and disabled in every mode.
// RULE_02 - Low-side-on mode connects output only while same phase low gate is active.
// RULE_03 - Single shunt uses OR of all low gate signals for connecting.
// RULE_04 - With several amplifiers each channel follows only its own low gate.
// RULE_05 - On-resistance sensing forces low-side-on mode whatever mode is programmed.
// RULE_06 - High-side-off mode connects during low-side on plus surrounding dead times.
// RULE_07 - Always-on mode keeps enabled outputs connected, ignoring gate signals.
// RULE_08 - Software sets amplifier enable and timing mode to leave always-off.
// RULE_09 - Inputs disconnect for programmed blanking time on both high gate edges.
// RULE_10 - During blanking output shows offset; inputs reconnect when interval ends.
// RULE_11 - Blanking triggers of all phases are ORed together.
// RULE_12 - One offset source select picks internal scaled or external reference for all.
// RULE_13 - Reference scaling field sets divide factor of internal offset level.
// RULE_14 - Separate positive and negative comparators with independent threshold fields.
// RULE_15 - Thresholds are shunt voltage, untouched by amplifier gain.
// RULE_16 - Optional deglitch filter before fault handler driving active-low fault output.
// RULE_17 - Truncation cuts active high side pulse at once on comparator trip; code truncates on positive comparators only, and not while blanking.
// RULE_18 - Enabled truncation bypasses the deglitch filter.
// RULE_19 - Fault pin reporting can be disabled while truncation stays active.
// RULE_20 - Over-current can optionally request a brake action.
// RULE_21 - Fully disabled protection ignores comparator events entirely.
// RULE_22 - Reaction settings may change while active, including repeat and latch.
// RULE_23 - Mode value 0 is low-side-on; with on-resistance sensing other values ignored.
// RULE_24 - Dead time is when neither gate of a phase is active; gates sampled synchronously.
module csg_top
    import csg_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [2:0] low_side_gate_signal,
    input wire logic [2:0] high_side_gate_signal,
    input wire logic [2:0] pos_cmp,
    input wire logic [2:0] neg_cmp,
    output logic [2:0] amp_enable,
    output logic [2:0] sense_output_pin_connect,
    output logic [2:0] amp_input_connect,
    output logic offset_on_output,
    output logic offset_source_select,
    output logic [2:0] ref_scale,
    output logic [3:0] positive_threshold_field,
    output logic [3:0] negative_threshold_field,
    output logic [2:0] high_side_gate_out,
    output logic brake_request,
    output logic fault_out_n
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    csg_amp_cfg_s amp_cfg_reg;
    csg_ocp_cfg_s ocp_cfg_reg;
    logic [7:0] blank_time;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic clr_pulse;
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic addr_ok;

    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
        end else if (ce) begin
            wr_pend <= addr_ok && hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr <= 8'h00;
        end else if (ce) begin
            wr_addr <= haddr;
        end
    end

    // Writes land in the data phase; the mode field may change at any time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            amp_cfg_reg <= csg_amp_cfg_s'(AMP_CFG_RST[10:0]);
            ocp_cfg_reg <= csg_ocp_cfg_s'(OCP_CFG_RST[15:0]);
            blank_time <= BLANK_CFG_RST[7:0];
        end else if (ce && wr_pend) begin
            if (wr_addr == AMP_CFG_OFS) begin
                amp_cfg_reg <= csg_amp_cfg_s'(hwdata[10:0]); // [RULE_08]
            end else if (wr_addr == OCP_CFG_OFS) begin
                ocp_cfg_reg <= csg_ocp_cfg_s'(hwdata[15:0]); // [RULE_22]
            end else if (wr_addr == BLANK_CFG_OFS) begin
                blank_time <= hwdata[BLANK_POS +: 8];
            end
        end
    end

    assign clr_pulse = ce && wr_pend && (wr_addr == STATUS_OFS) && hwdata[ST_FAULT_POS];

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (haddr == AMP_CFG_OFS) begin
            next_rdata[10:0] = amp_cfg_reg;
        end else if (haddr == OCP_CFG_OFS) begin
            next_rdata[15:0] = ocp_cfg_reg;
        end else if (haddr == BLANK_CFG_OFS) begin
            next_rdata[BLANK_POS +: 8] = blank_time;
        end else if (haddr == STATUS_OFS) begin
            next_rdata = status_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && addr_ok && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Gate sampling and timing mode
    // ------------------------------------------------------------
    logic [2:0] gl_q;
    logic [2:0] gh_q;
    logic [2:0] gh_prev;
    logic [2:0] ls_src;
    logic [2:0] dead;
    logic [2:0] next_connect;
    logic [1:0] eff_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gl_q <= 3'h0;
        end else if (ce) begin
            gl_q <= low_side_gate_signal; // [RULE_24]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gh_q <= 3'h0;
            gh_prev <= 3'h0;
        end else if (ce) begin
            gh_q <= high_side_gate_signal; // [RULE_24]
            gh_prev <= gh_q;
        end
    end

    assign eff_mode = amp_cfg_reg.rdson ? 2'h0 : amp_cfg_reg.timing_mode_field; // [RULE_05] [RULE_23]
    assign ls_src = amp_cfg_reg.single_shunt ? {3{|gl_q}} : gl_q; // [RULE_03] [RULE_04]

    // Spare mode code falls back to low-side-on, the safe choice for the inputs
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_ch
            logic own_dead;
            assign own_dead = ~gl_q[ch] & ~gh_q[ch]; // [RULE_24]
            assign dead[ch] = amp_cfg_reg.single_shunt ? &(~gl_q & ~gh_q) : own_dead;
            always_comb begin
                case (csg_tmode_e'(eff_mode))
                    CSG_LOW_SIDE_ON_MODE: next_connect[ch] = ls_src[ch]; // [RULE_02]
                    CSG_HIGH_SIDE_OFF_MODE: next_connect[ch] = ls_src[ch] | dead[ch]; // [RULE_06]
                    CSG_ALWAYS_ON_MODE: next_connect[ch] = 1'b1; // [RULE_07]
                    default: next_connect[ch] = ls_src[ch];
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Blanking
    // ------------------------------------------------------------
    logic [7:0] blank_cnt;
    logic blank_trig;
    logic blanking;

    assign blank_trig = |(gh_q ^ gh_prev); // [RULE_09] [RULE_11]
    assign blanking = blank_cnt != 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blank_cnt <= 8'h00;
        end else if (ce) begin
            if (blank_trig) begin
                blank_cnt <= blank_time; // [RULE_09]
            end else if (blanking) begin
                blank_cnt <= blank_cnt - 8'h01; // [RULE_10]
            end
        end
    end

    // ------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            amp_enable <= 3'h0;
            sense_output_pin_connect <= 3'h0;
            amp_input_connect <= 3'h0;
            offset_on_output <= 1'b0;
            offset_source_select <= 1'b0;
            ref_scale <= 3'h0;
            positive_threshold_field <= 4'h0;
            negative_threshold_field <= 4'h0;
        end else if (ce) begin
            amp_enable <= amp_cfg_reg.amp_en; // [RULE_01]
            sense_output_pin_connect <= next_connect & amp_cfg_reg.amp_en; // [RULE_01]
            amp_input_connect <= amp_cfg_reg.amp_en & {3{~(blanking | blank_trig)}}; // [RULE_10]
            offset_on_output <= blanking | blank_trig; // [RULE_10]
            offset_source_select <= amp_cfg_reg.offset_source_select; // [RULE_12]
            ref_scale <= amp_cfg_reg.ref_scale; // [RULE_13]
            // Raw shunt-voltage codes; gain never enters here
            positive_threshold_field <= ocp_cfg_reg.positive_threshold_field; // [RULE_14] [RULE_15]
            negative_threshold_field <= ocp_cfg_reg.negative_threshold_field; // [RULE_14]
        end
    end

    // ------------------------------------------------------------
    // Over-current reaction
    // ------------------------------------------------------------
    logic raw_event;
    logic trunc_en;
    logic trunc_now;
    logic trunc_hold;
    logic [4:0] dg_cnt;
    logic [4:0] dg_target;
    logic filt_event;
    logic handler_event;
    logic evt_prev;
    logic evt_rise;
    logic [4:0] trip_cnt;
    logic fault_flag;
    logic happened;
    logic trip;

    assign raw_event = (|pos_cmp | |neg_cmp) & ~ocp_cfg_reg.ocp_dis; // [RULE_21]
    assign trunc_en = ~ocp_cfg_reg.truncation_disable_field;
    // Blanking also masks truncation so switching ringing cannot cut the pulse
    assign trunc_now = trunc_en & (|pos_cmp) & ~ocp_cfg_reg.ocp_dis & ~blanking; // [RULE_17]
    assign dg_target = DEGLITCH_BASE << ocp_cfg_reg.overcurrent_deglitch_field;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dg_cnt <= 5'h00;
        end else if (ce) begin
            if (!raw_event) begin
                dg_cnt <= 5'h00;
            end else if (dg_cnt != 5'h1f) begin
                dg_cnt <= dg_cnt + 5'h01;
            end
        end
    end

    always_comb begin
        if (trunc_en || ocp_cfg_reg.overcurrent_deglitch_field == 2'h0) begin
            filt_event = raw_event; // [RULE_18]
        end else begin
            filt_event = raw_event && (dg_cnt >= dg_target); // [RULE_16]
        end
    end

    assign handler_event = filt_event & ~blanking;

    // Truncation holds until every high side gate falls, i.e. the next PWM period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trunc_hold <= 1'b0;
        end else if (ce) begin
            if (trunc_now) begin
                trunc_hold <= 1'b1; // [RULE_17]
            end else if (gh_q == 3'h0) begin
                trunc_hold <= 1'b0;
            end
        end
    end

    // Combinational path: the cut does not wait for a clock edge or for software
    assign high_side_gate_out = high_side_gate_signal & {3{~(trunc_now | trunc_hold)}}; // [RULE_17]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_prev <= 1'b0;
        end else if (ce) begin
            evt_prev <= handler_event;
        end
    end

    // One count per event
    assign evt_rise = handler_event & ~evt_prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trip_cnt <= 5'h00;
        end else if (ce) begin
            if (clr_pulse) begin
                trip_cnt <= 5'h00;
            end else if (evt_rise && trip_cnt != REPEAT_COUNT) begin
                trip_cnt <= trip_cnt + 5'h01; // [RULE_22]
            end
        end
    end

    assign trip = ocp_cfg_reg.repeat_trip ? (trip_cnt == REPEAT_COUNT) : handler_event; // [RULE_22]

    // Set beats clear; a latched fault clears only once the condition is gone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_flag <= 1'b0;
        end else if (ce) begin
            if (trip) begin
                fault_flag <= 1'b1; // [RULE_16]
            end else if (clr_pulse && (!ocp_cfg_reg.overcurrent_latch_field || !raw_event)) begin
                fault_flag <= 1'b0; // [RULE_22]
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            happened <= 1'b0;
        end else if (ce) begin
            if (trip) begin
                happened <= 1'b1;
            end else if (clr_pulse) begin
                happened <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_out_n <= 1'b1;
        end else if (ce) begin
            fault_out_n <= ~(fault_flag & ~ocp_cfg_reg.report_dis); // [RULE_16] [RULE_19]
        end
    end

    // Brake ends with the fault clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brake_request <= 1'b0;
        end else if (ce) begin
            brake_request <= fault_flag & ocp_cfg_reg.brake_en; // [RULE_20]
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_CONNECT_POS +: 3] = sense_output_pin_connect;
        status_word[ST_BLANKING_POS] = blanking;
        status_word[ST_FAULT_POS] = fault_flag;
        status_word[ST_POS_CMP_POS] = |pos_cmp;
        status_word[ST_NEG_CMP_POS] = |neg_cmp;
        status_word[ST_TRUNC_POS] = trunc_hold;
        status_word[ST_HAPPENED_POS] = happened;
    end
endmodule

// ---- verif/csg_top_sva.sv ----
// Checker with port-level properties of the sense gating block
`timescale 1ns/100ps
module csg_top_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [2:0] pos_cmp,
    input wire logic [2:0] high_side_gate_signal,
    input wire logic [2:0] amp_enable,
    input wire logic [2:0] sense_output_pin_connect,
    input wire logic [2:0] amp_input_connect,
    input wire logic offset_on_output,
    input wire logic offset_source_select,
    input wire logic [2:0] ref_scale,
    input wire logic [3:0] positive_threshold_field,
    input wire logic [3:0] negative_threshold_field,
    input wire logic [2:0] high_side_gate_out,
    input wire logic brake_request,
    input wire logic fault_out_n
);
    // ------------------------------
    // Properties
    // ------------------------------
    logic wr_take;
    logic rd_take;
    logic cut;
    assign wr_take = ce && hsel && hready && htrans[1] && hwrite;
    assign rd_take = ce && hsel && hready && htrans[1] && !hwrite;
    assign cut = high_side_gate_out != high_side_gate_signal;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_disabled_off: assert property ((sense_output_pin_connect & ~amp_enable) == 3'h0)
        else $error("Disabled channel connected");
    a_trunc_mask: assert property ((high_side_gate_out & ~high_side_gate_signal) == 3'h0)
        else $error("High gate out set without gate in");
    a_cut_cause: assert property ($rose(cut) |-> pos_cmp != 3'h0 || $past(pos_cmp) != 3'h0)
        else $error("Cut without positive comparator");
    a_blank_start: assert property ($changed(high_side_gate_signal) |-> ##2 offset_on_output)
        else $error("No blanking after high gate edge");
    a_blank_cause: assert property ($rose(offset_on_output) |->
        $past(high_side_gate_signal, 2) != $past(high_side_gate_signal, 3))
        else $error("Blanking without high gate edge");
    a_blank_inputs: assert property (offset_on_output |-> amp_input_connect == 3'h0)
        else $error("Inputs connected while blanking");
    a_inputs_back: assert property (!offset_on_output |->
        amp_input_connect == amp_enable)
        else $error("Inputs off outside blanking");
    a_cfg_change: assert property (
        $changed({amp_enable, offset_source_select, ref_scale,
        positive_threshold_field, negative_threshold_field}) |->
        $past(wr_take, 2) || $past(wr_take, 3))
        else $error("Config output changed without write");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_take))
        else $error("Read data changed without read");
    a_ready_ce: assert property (hreadyout == ce)
        else $error("Ready does not follow clock enable");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("Response not okay");

    c_blank: cover property ($rose(offset_on_output));
    c_cut: cover property ($rose(cut));
    c_fault: cover property ($fell(fault_out_n));
    c_brake: cover property ($rose(brake_request));
endmodule

bind csg_top csg_top_sva i_sva (.*);

// ---- verif/csg_pwm_model.sv ----
// PWM source and comparator model feeding the gate and comparator inputs
`timescale 1ns/100ps
module csg_pwm_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic [2:0] phase_mask,
    input wire logic [3:0] duty,
    input wire logic trip,
    output logic [2:0] low_side_gate_signal,
    output logic [2:0] high_side_gate_signal,
    output logic [2:0] pos_cmp,
    output logic [2:0] neg_cmp
);
    // ------------------------------
    // Three legs, 16-cycle period
    // ------------------------------
    logic [3:0] cnt;
    logic [3:0] c;
    logic on;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 4'h0;
            {low_side_gate_signal, high_side_gate_signal, pos_cmp, neg_cmp} <= 12'h000;
        end else begin
            cnt <= cnt + 4'h1;
            for (int p = 0; p < 3; p++) begin
                c = cnt + 4'(5 * p);
                on = run && phase_mask[p];
                // Idle cycles either side of low gate avoid shoot-through
                high_side_gate_signal[p] <= on && c < duty;
                low_side_gate_signal[p] <= on && {1'b0, c} >= {1'b0, duty} + 5'h2 && c < 4'hf;
                // Six-cycle pulse: too short for the longest deglitch
                pos_cmp[p] <= trip && on && c < duty && c > 4'h3;
                neg_cmp[p] <= trip && on && c == 4'he;
            end
        end
    end
endmodule

// ---- verif/csg_top_test.sv ----
// Self-checking bench of the sense gating block with its PWM model
`timescale 1ns/100ps
module csg_top_test
    import csg_pkg::*;
;
    // ------------------------------
    // Signals, clock and instances
    // ------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout, hresp, offset_on_output, offset_source_select, brake_request, fault_out_n;
    logic [31:0] hrdata, rd, cfg;
    logic [2:0] low_side_gate_signal, high_side_gate_signal, pos_cmp, neg_cmp, amp_enable;
    logic [2:0] sense_output_pin_connect, amp_input_connect, ref_scale, high_side_gate_out;
    logic [3:0] positive_threshold_field, negative_threshold_field;
    logic run = 1'b0;
    logic [2:0] phase_mask = 3'h0;
    logic [3:0] duty = 4'h8;
    logic trip = 1'b0;
    logic [2:0] ls1, ls2, hs1, hs2;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 19;
    int cut_n, flt_n, brk_n, n, w;
    logic [31:0] oc [8] = '{32'h2000, 32'h1000, 32'h6000, 32'h2400, 32'h2300, 32'h2700,
        32'h2800, 32'ha000};
    logic [2:0] ex [8] = '{3'h7, 3'h1, 3'h0, 3'h6, 3'h7, 3'h0, 3'h7, 3'h1};
    logic [7:0] ra [4] = '{AMP_CFG_OFS, OCP_CFG_OFS, BLANK_CFG_OFS, 8'h10};
    logic [31:0] rv [4] = '{AMP_CFG_RST, OCP_CFG_RST, BLANK_CFG_RST, 32'h0};

    assign hready = hreadyout;
    always #2 hclk = ~hclk;
    csg_top i_dut (.*);
    csg_pwm_model i_pwm (.*);

    always @(posedge hclk) begin
        ls1 <= low_side_gate_signal;
        ls2 <= ls1;
        hs1 <= high_side_gate_signal;
        hs2 <= hs1;
    end
    always @(negedge hclk) begin
        if (high_side_gate_out !== high_side_gate_signal) cut_n++;
        if (fault_out_n === 1'b0) flt_n++;
        if (brake_request === 1'b1) brk_n++;
    end

    // ------------------------------
    // Expectation, bus and report
    // ------------------------------
    function automatic logic [2:0] exp_conn(input logic [31:0] c, input logic [2:0] l,
        input logic [2:0] h);
        logic [1:0] m;
        logic [2:0] src;
        logic [2:0] dead;
        m = (c[4] || c[6:5] == 2'h3) ? 2'h0 : c[6:5];
        src = c[3] ? {3{|l}} : l;
        dead = c[3] ? {3{~|(l | h)}} : ~(l | h);
        if (m == 2'h2) src = 3'h7;
        else if (m == 2'h1) src = src | dead;
        return src & c[2:0];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic guard(input int cnt);
        if (cnt >= 64) begin
            $display("BAD t=%0t got=%h exp=%h", $time, cnt, 64);
            fail_count++;
            give_verdict();
        end
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && k < 64) begin
            @(posedge hclk);
            k++;
        end
        guard(k);
    endtask

    // Single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, ra[k], 32'h0);
            chk(rd, rv[k]);
        end
        cfg = ($random(seed) & 32'hffff) | 32'h4000;
        bus(1'b1, OCP_CFG_OFS, cfg);
        bus(1'b1, 8'h10, cfg);
        bus(1'b0, OCP_CFG_OFS, 32'h0);
        chk(rd, cfg);
        chk({positive_threshold_field, negative_threshold_field}, {cfg[3:0], cfg[7:4]});
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        $display("register test done");
        run <= 1'b1;
        phase_mask <= 3'h7;
        for (int k = 0; k < 16; k++) begin
            cfg = ($random(seed) & 32'h787) | {25'h0, k[1:0], k[3], k[2], 3'h0};
            bus(1'b1, AMP_CFG_OFS, cfg);
            duty <= 4'h2 + 4'($random(seed) & 7);
            bus(1'b0, AMP_CFG_OFS, 32'h0);
            chk(rd, cfg);
            chk({ref_scale, offset_source_select}, cfg[10:7]);
            repeat (24) begin
                @(negedge hclk);
                chk(sense_output_pin_connect, exp_conn(cfg, ls2, hs2));
            end
            chk(amp_enable, cfg[2:0]);
        end
        $display("gating test done");
        for (int k = 0; k < 3; k++) begin
            cfg = 1 + ($random(seed) & 3);
            bus(1'b1, BLANK_CFG_OFS, cfg);
            phase_mask <= 3'h1 << k;
            duty <= 4'h8;
            repeat (20) @(negedge hclk);
            w = 0;
            while (offset_on_output !== 1'b0 && w < 64) begin @(negedge hclk); w++; end
            while (offset_on_output !== 1'b1 && w < 64) begin @(negedge hclk); w++; end
            guard(w);
            n = 0;
            while (offset_on_output === 1'b1 && n < 64) begin
                chk(amp_input_connect, 3'h0);
                n++;
                @(negedge hclk);
            end
            chk(n, cfg + 1);
        end
        $display("blanking test done");
        bus(1'b1, BLANK_CFG_OFS, 32'h0);
        phase_mask <= 3'h1;
        duty <= 4'ha;
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, OCP_CFG_OFS, oc[k]);
            {cut_n, flt_n, brk_n} = '0;
            trip <= 1'b1;
            repeat (48) @(posedge hclk);
            trip <= 1'b0;
            chk({brk_n != 0, flt_n != 0, cut_n != 0}, ex[k]);
            repeat (8) @(posedge hclk);
            bus(1'b1, STATUS_OFS, 32'h10);
            repeat (4) @(negedge hclk);
            chk({brake_request, fault_out_n}, 2'h1);
        end
        $display("protection test done");
        give_verdict();
    end
endmodule
